// [hw/bdmm_regs.svh]
/*
 * Register offsets, field positions, reset values and timing counts of
 * the byte DMA and memory map block.
 * Assumes a 32-bit AHB-Lite bus with one register per aligned word.
 */
`ifndef BDMM_REGS_SVH
`define BDMM_REGS_SVH

// ----------------------------------------------------------------------
// Register word indices (byte address = 4 * index)
// ----------------------------------------------------------------------
`define BDMM_IDX_CTRL 4'h0
`define BDMM_IDX_IADDR 4'h1
`define BDMM_IDX_EADDR 4'h2
`define BDMM_IDX_PAGE 4'h3
`define BDMM_IDX_WCNT 4'h4
`define BDMM_IDX_OVLAY 4'h5
`define BDMM_IDX_WAIT 4'h6
`define BDMM_IDX_IOWAIT 4'h7
`define BDMM_IDX_CMSEN 4'h8
`define BDMM_IDX_STATUS 4'h9

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define BDMM_CTRL_FMT 1:0
`define BDMM_CTRL_DIR 2
`define BDMM_CTRL_CTX 3
`define BDMM_OVL_PM 1:0
`define BDMM_OVL_DM 5:4
`define BDMM_WAIT_DATA 2:0
`define BDMM_WAIT_BYTE 6:4

// ----------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------
`define BDMM_CMSEN_RESET 4'hb
`define BDMM_WAIT_RESET 3'h7
`define BDMM_SYNC_STAGES 4'h2

`endif

// [hw/bdmm_pkg.sv]
/*
 * Types of the byte DMA and memory map block.
 * Assumes the constants of bdmm_regs.svh for the numbers.
 */
package bdmm_pkg;

  typedef enum logic [2:0] {
    X_IDLE = 3'b001,
    X_CORE = 3'b010,
    X_BYTE = 3'b100
  } bdmm_xst_e;

  typedef enum logic [3:0] {
    D_IDLE = 4'b0001,
    D_FETCH = 4'b0010,
    D_BYTES = 4'b0100,
    D_STORE = 4'b1000
  } bdmm_dst_e;

  typedef enum logic [1:0] {
    SP_PM = 2'h0,
    SP_DM = 2'h1,
    SP_IO = 2'h2
  } bdmm_space_e;

  // Core request toward the memory map
  typedef struct packed {
    logic req;
    bdmm_space_e space;
    logic we;
    logic [13:0] addr;
    logic [23:0] wdata;
  } bdmm_core_req_s;

  // On-chip memory port used by the byte DMA engine
  typedef struct packed {
    logic req;
    logic is_pm;
    logic we;
    logic [13:0] addr;
    logic [23:0] wdata;
  } bdmm_mem_s;

  // External bus pins; every _n is active low, oe_n low means driving
  typedef struct packed {
    logic [13:0] addr;
    logic [23:0] data;
    logic [2:0] data_oe_n;
    logic pms_n;
    logic dms_n;
    logic bms_n;
    logic io_space_select_n;
    logic cms_n;
    logic rd_n;
    logic wr_n;
    logic ctl_oe_n;
    logic bus_grant_n;
  } bdmm_ext_s;

  typedef struct packed {
    logic ahb_wr;
    logic [3:0] ahb_idx;
    logic [31:0] hrdata;
    logic hreadyout;
    logic [1:0] fmt;
    logic dir;
    logic ctx;
    logic [13:0] iaddr;
    logic [13:0] eaddr;
    logic [7:0] page;
    logic [13:0] wcnt;
    logic [1:0] pmov;
    logic [1:0] dmov;
    logic [2:0] data_wait_count;
    logic [2:0] bwait;
    logic [11:0] iowait;
    logic [3:0] cms_en;
    logic map_s1;
    logic map_s2;
    logic br_s1;
    logic br_s2;
    logic [23:0] din_s1;
    logic [23:0] din_s2;
    bdmm_xst_e xst;
    logic [3:0] xcnt;
    logic core_ack;
    logic core_ext;
    logic [23:0] core_rdata;
    bdmm_ext_s ext;
    bdmm_dst_e dst;
    logic [1:0] blft;
    logic [23:0] shift;
    logic byte_req;
    logic byte_done;
    bdmm_mem_s mem;
    logic irq;
    logic hold;
    logic restart;
  } bdmm_state_s;

endpackage : bdmm_pkg

// [hw/bdmm_top.sv]
/*
 * Memory map decoder, external bus sequencer and byte DMA engine.
 * Assumes a same-clock core request port and an on-chip memory that
 * returns read data in the same cycle as its request on mem_out; external pins are
 * synchronised here.
 */
`timescale 1ns/1ps
`default_nettype none
`include "bdmm_regs.svh"

module bdmm_top (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire bdmm_pkg::bdmm_core_req_s core_req,
  output logic core_ack,
  output logic core_ext,
  output logic [23:0] core_rdata,
  output logic core_hold,
  output logic core_restart,
  output logic dma_irq,
  output bdmm_pkg::bdmm_mem_s mem_out,
  input wire logic [23:0] mem_rdata,
  input wire logic map_select_pin,
  input wire logic bus_req_n,
  input wire logic [23:0] ext_data_in,
  output bdmm_pkg::bdmm_ext_s ext_out
);

  bdmm_pkg::bdmm_state_s s_q;
  bdmm_pkg::bdmm_state_s s_d;

  // --------------------------------------------------------------------
  // Address mapping
  // --------------------------------------------------------------------
  function automatic logic map_is_ext(bdmm_pkg::bdmm_space_e sp,
                                      logic [13:0] a, logic [1:0] pov,
                                      logic [1:0] dov, logic map);
    logic r;
    r = 1'b1;
    if (sp == bdmm_pkg::SP_PM) begin
      if (map) begin
        r = ~a[13];
      end else begin
        r = a[13] && (pov != 2'h0);
      end
    end else if (sp == bdmm_pkg::SP_DM) begin
      // Control words at the top of data space are always internal
      r = !map && !a[13] && (dov != 2'h0);
    end
    return r;
  endfunction : map_is_ext

  function automatic logic [13:0] map_addr(bdmm_pkg::bdmm_space_e sp,
                                           logic [13:0] a, logic [1:0] pov,
                                           logic [1:0] dov, logic map);
    logic [13:0] r;
    r = a;
    if (sp == bdmm_pkg::SP_IO) begin
      r = {3'h0, a[10:0]};
    end else if (sp == bdmm_pkg::SP_PM && !map) begin
      r = {pov == 2'h2, a[12:0]};
    end else if (sp == bdmm_pkg::SP_DM) begin
      r = {dov == 2'h2, a[12:0]};
    end
    return r;
  endfunction : map_addr

  function automatic logic [1:0] fmt_bytes(logic [1:0] f);
    return (f == 2'h0) ? 2'h3 : ((f == 2'h1) ? 2'h2 : 2'h1);
  endfunction : fmt_bytes

  logic core_is_ext;
  logic [2:0] core_wait;

  always_comb begin
    core_is_ext = map_is_ext(core_req.space, core_req.addr, s_q.pmov,
                             s_q.dmov, s_q.map_s2);
    core_wait = s_q.data_wait_count;
    if (core_req.space == bdmm_pkg::SP_IO) begin
      case (core_req.addr[10:9])
        2'h0: core_wait = s_q.iowait[2:0];
        2'h1: core_wait = s_q.iowait[5:3];
        2'h2: core_wait = s_q.iowait[8:6];
        default: core_wait = s_q.iowait[11:9];
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------
  logic word_done;
  logic [13:0] ea_inc;

  always_comb begin
    s_d = s_q;
    word_done = 1'b0;
    ea_inc = s_q.eaddr + 14'h1;
    s_d.map_s1 = map_select_pin;
    s_d.map_s2 = s_q.map_s1;
    s_d.br_s1 = ~bus_req_n;
    s_d.br_s2 = s_q.br_s1;
    s_d.din_s1 = ext_data_in;
    s_d.din_s2 = s_q.din_s1;
    s_d.core_ack = 1'b0;
    s_d.byte_done = 1'b0;
    s_d.irq = 1'b0;
    s_d.restart = 1'b0;
    s_d.mem.req = 1'b0;
    s_d.mem.we = 1'b0;
    s_d.ahb_wr = 1'b0;
    s_d.hreadyout = 1'b1;

    // Bus slave: read data is prepared in the address phase
    if (hsel && htrans[1] && hready) begin
      // Writes outside the register window are dropped here
      s_d.ahb_wr = hwrite && (haddr[31:6] == 26'h0);
      s_d.ahb_idx = haddr[5:2];
      s_d.hrdata = 32'h0;
      if (haddr[31:6] != 26'h0) begin
        s_d.hrdata = 32'h0;
      end else if (haddr[5:2] == `BDMM_IDX_CTRL) begin
        s_d.hrdata = {28'h0, s_q.ctx, s_q.dir, s_q.fmt};
      end else if (haddr[5:2] == `BDMM_IDX_IADDR) begin
        s_d.hrdata = {18'h0, s_q.iaddr};
      end else if (haddr[5:2] == `BDMM_IDX_EADDR) begin
        s_d.hrdata = {18'h0, s_q.eaddr};
      end else if (haddr[5:2] == `BDMM_IDX_PAGE) begin
        s_d.hrdata = {24'h0, s_q.page};
      end else if (haddr[5:2] == `BDMM_IDX_WCNT) begin
        s_d.hrdata = {18'h0, s_q.wcnt};
      end else if (haddr[5:2] == `BDMM_IDX_OVLAY) begin
        s_d.hrdata = {26'h0, s_q.dmov, 2'h0, s_q.pmov};
      end else if (haddr[5:2] == `BDMM_IDX_WAIT) begin
        s_d.hrdata = {25'h0, s_q.bwait, 1'b0, s_q.data_wait_count};
      end else if (haddr[5:2] == `BDMM_IDX_IOWAIT) begin
        s_d.hrdata = {20'h0, s_q.iowait};
      end else if (haddr[5:2] == `BDMM_IDX_CMSEN) begin
        s_d.hrdata = {28'h0, s_q.cms_en};
      end else if (haddr[5:2] == `BDMM_IDX_STATUS) begin
        s_d.hrdata = {29'h0, s_q.map_s2, s_q.hold,
                      s_q.dst != bdmm_pkg::D_IDLE};
      end
    end else if (haddr[31:6] == 26'h0 && hsel) begin
      s_d.ahb_idx = s_q.ahb_idx;
    end

    // Core access: internal in one cycle, external through the bus
    if (core_req.req && !s_q.core_ack && !core_is_ext &&
        s_q.xst == bdmm_pkg::X_IDLE) begin
      s_d.core_ack = 1'b1;
      s_d.core_ext = 1'b0;
    end

    // External bus sequencer
    case (s_q.xst)
      bdmm_pkg::X_IDLE: begin
        s_d.ext.ctl_oe_n = 1'b0;
        s_d.ext.bus_grant_n = 1'b1;
        s_d.ext.data_oe_n = 3'h7;
        if (s_q.br_s2) begin
          // Granted bus: pins float just as the other selects do
          s_d.ext.ctl_oe_n = 1'b1;
          s_d.ext.bus_grant_n = 1'b0;
        end else if (core_req.req && core_is_ext && !s_q.core_ack) begin
          s_d.xst = bdmm_pkg::X_CORE;
          s_d.xcnt = {1'b0, core_wait} + `BDMM_SYNC_STAGES;
          s_d.ext.addr = map_addr(core_req.space, core_req.addr, s_q.pmov,
                                  s_q.dmov, s_q.map_s2);
          s_d.ext.data = core_req.wdata;
          s_d.ext.data_oe_n = core_req.we ? 3'h0 : 3'h7;
          s_d.ext.pms_n = core_req.space != bdmm_pkg::SP_PM;
          s_d.ext.dms_n = core_req.space != bdmm_pkg::SP_DM;
          s_d.ext.io_space_select_n = core_req.space != bdmm_pkg::SP_IO;
          s_d.ext.rd_n = core_req.we;
          s_d.ext.wr_n = ~core_req.we;
        end else if (s_q.byte_req) begin
          s_d.xst = bdmm_pkg::X_BYTE;
          s_d.xcnt = {1'b0, s_q.bwait} + `BDMM_SYNC_STAGES;
          s_d.ext.addr = s_q.eaddr;
          s_d.ext.data = {s_q.page, s_q.shift[23:16], 8'h0};
          s_d.ext.data_oe_n = s_q.dir ? 3'h1 : 3'h3;
          s_d.ext.bms_n = 1'b0;
          s_d.ext.rd_n = s_q.dir;
          s_d.ext.wr_n = ~s_q.dir;
        end
      end
      default: begin
        s_d.xcnt = s_q.xcnt - 4'h1;
        if (s_q.xcnt == 4'h0) begin
          s_d.xst = bdmm_pkg::X_IDLE;
          {s_d.ext.pms_n, s_d.ext.dms_n, s_d.ext.bms_n} = 3'h7;
          s_d.ext.io_space_select_n = 1'b1;
          s_d.ext.rd_n = 1'b1;
          s_d.ext.wr_n = 1'b1;
          s_d.ext.data_oe_n = 3'h7;
          if (s_q.xst == bdmm_pkg::X_CORE) begin
            s_d.core_ack = 1'b1;
            s_d.core_ext = 1'b1;
            s_d.core_rdata = s_q.din_s2;
          end else begin
            s_d.byte_done = 1'b1;
            s_d.byte_req = 1'b0;
          end
        end
      end
    endcase
    // Byte DMA engine; memory side is always on chip
    s_d.mem.is_pm = s_q.fmt == 2'h0;
    s_d.mem.addr = s_q.iaddr;
    case (s_q.dst)
      bdmm_pkg::D_IDLE: begin
        if (s_q.wcnt != 14'h0) begin
          s_d.blft = fmt_bytes(s_q.fmt);
          s_d.shift = 24'h0;
          if (s_q.dir) begin
            s_d.dst = bdmm_pkg::D_FETCH;
            s_d.mem.req = 1'b1;
          end else begin
            s_d.dst = bdmm_pkg::D_BYTES;
            s_d.byte_req = 1'b1;
          end
        end
      end
      bdmm_pkg::D_FETCH: begin
        case (s_q.fmt) // Left-align so the top byte leaves first
          2'h0: s_d.shift = mem_rdata;
          2'h1: s_d.shift = {mem_rdata[15:0], 8'h0};
          2'h2: s_d.shift = {mem_rdata[15:8], 16'h0};
          default: s_d.shift = {mem_rdata[7:0], 16'h0};
        endcase
        s_d.dst = bdmm_pkg::D_BYTES;
        s_d.byte_req = 1'b1;
      end
      bdmm_pkg::D_BYTES: begin
        if (s_q.byte_done) begin
          s_d.eaddr = ea_inc;
          if (ea_inc == 14'h0) begin
            s_d.page = s_q.page + 8'h1;
          end
          s_d.shift = s_q.dir ? {s_q.shift[15:0], 8'h0} :
                      {s_q.shift[15:0], s_q.din_s2[15:8]};
          s_d.blft = s_q.blft - 2'h1;
          if (s_q.blft != 2'h1) begin
            s_d.byte_req = 1'b1;
          end else if (s_q.dir) begin
            word_done = 1'b1;
          end else begin
            s_d.dst = bdmm_pkg::D_STORE;
            s_d.mem.req = 1'b1;
            s_d.mem.we = 1'b1;
            case (s_q.fmt)
              2'h0: s_d.mem.wdata = s_d.shift;
              2'h1: s_d.mem.wdata = {8'h0, s_d.shift[15:0]};
              2'h2: s_d.mem.wdata = {8'h0, s_d.shift[7:0], 8'h0};
              default: s_d.mem.wdata = {16'h0, s_d.shift[7:0]};
            endcase
          end
        end
      end
      default: begin
        word_done = 1'b1;
      end
    endcase
    if (word_done) begin
      s_d.wcnt = s_q.wcnt - 14'h1;
      s_d.iaddr = s_q.iaddr + 14'h1;
      s_d.dst = bdmm_pkg::D_IDLE;
      if (s_q.wcnt == 14'h1) begin
        s_d.irq = 1'b1;
        s_d.restart = s_q.ctx;
      end
    end
    s_d.hold = s_q.ctx && (s_d.wcnt != 14'h0);

    // Bus slave: write data phase; software write wins over hardware
    if (s_q.ahb_wr) begin
      if (s_q.ahb_idx == `BDMM_IDX_CTRL) begin
        s_d.fmt = hwdata[`BDMM_CTRL_FMT];
        s_d.dir = hwdata[`BDMM_CTRL_DIR];
        s_d.ctx = hwdata[`BDMM_CTRL_CTX];
      end else if (s_q.ahb_idx == `BDMM_IDX_IADDR) begin
        s_d.iaddr = hwdata[13:0];
      end else if (s_q.ahb_idx == `BDMM_IDX_EADDR) begin
        s_d.eaddr = hwdata[13:0];
      end else if (s_q.ahb_idx == `BDMM_IDX_PAGE) begin
        s_d.page = hwdata[7:0];
      end else if (s_q.ahb_idx == `BDMM_IDX_WCNT) begin
        s_d.wcnt = hwdata[13:0];
      end else if (s_q.ahb_idx == `BDMM_IDX_OVLAY) begin
        // Plain storage, nothing pushes these on interrupt entry
        s_d.pmov = hwdata[`BDMM_OVL_PM];
        s_d.dmov = hwdata[`BDMM_OVL_DM];
      end else if (s_q.ahb_idx == `BDMM_IDX_WAIT) begin
        s_d.data_wait_count = hwdata[`BDMM_WAIT_DATA];
        s_d.bwait = hwdata[`BDMM_WAIT_BYTE];
      end else if (s_q.ahb_idx == `BDMM_IDX_IOWAIT) begin
        s_d.iowait = hwdata[11:0];
      end else if (s_q.ahb_idx == `BDMM_IDX_CMSEN) begin
        s_d.cms_en = hwdata[3:0];
      end
    end
    // New enables apply together with the selects they gate
    s_d.ext.cms_n = ~|(s_d.cms_en & ~{s_d.ext.io_space_select_n, s_d.ext.bms_n,
                                       s_d.ext.dms_n, s_d.ext.pms_n});
  end

  // --------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s_q <= '0;
      s_q.xst <= bdmm_pkg::X_IDLE;
      s_q.dst <= bdmm_pkg::D_IDLE;
      s_q.hreadyout <= 1'b1;
      s_q.data_wait_count <= `BDMM_WAIT_RESET;
      s_q.bwait <= `BDMM_WAIT_RESET;
      s_q.iowait <= {4{`BDMM_WAIT_RESET}};
      s_q.cms_en <= `BDMM_CMSEN_RESET;
      s_q.ext.data_oe_n <= 3'h7;
      s_q.ext.pms_n <= 1'b1;
      s_q.ext.dms_n <= 1'b1;
      s_q.ext.bms_n <= 1'b1;
      s_q.ext.io_space_select_n <= 1'b1;
      s_q.ext.cms_n <= 1'b1;
      s_q.ext.rd_n <= 1'b1;
      s_q.ext.wr_n <= 1'b1;
      s_q.ext.bus_grant_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign hreadyout = s_q.hreadyout;
  assign hresp = 1'b0;
  assign hrdata = s_q.hrdata;
  assign core_ack = s_q.core_ack;
  assign core_ext = s_q.core_ext;
  assign core_rdata = s_q.core_rdata;
  assign core_hold = s_q.hold;
  assign core_restart = s_q.restart;
  assign dma_irq = s_q.irq;
  assign mem_out = s_q.mem;
  assign ext_out = s_q.ext;

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  sequence seq_count_write;
    s_q.ahb_wr && s_q.ahb_idx == `BDMM_IDX_WCNT && hwdata[13:0] != 14'h0;
  endsequence

  sequence seq_engine_busy;
    s_q.dst != bdmm_pkg::D_IDLE;
  endsequence

  a_cms_follows: assert property (
    s_q.ext.cms_n == ~|(s_q.cms_en & ~{s_q.ext.io_space_select_n, s_q.ext.bms_n,
                                        s_q.ext.dms_n, s_q.ext.pms_n}))
    else $error("composite select does not follow enabled selects");

  a_cms_reset: assert property (
    $past(reset) |-> s_q.cms_en == `BDMM_CMSEN_RESET)
    else $error("composite enables wrong after reset");

  a_mem_one_cycle: assert property (
    s_q.mem.req |=> !s_q.mem.req)
    else $error("on-chip memory used for more than one cycle");

  a_count_starts: assert property (
    seq_count_write ##1 !s_q.hold |-> ##[1:2] seq_engine_busy)
    else $error("nonzero word count did not start engine");

  a_irq_at_zero: assert property (
    s_q.irq |-> s_q.wcnt == 14'h0 && s_q.dst == bdmm_pkg::D_IDLE)
    else $error("done pulse while words remain");

  a_core_first: assert property (
    s_q.xst == bdmm_pkg::X_IDLE && !s_q.br_s2 && s_q.byte_req &&
    core_req.req && core_is_ext && !s_q.core_ack
    |=> s_q.xst == bdmm_pkg::X_CORE)
    else $error("byte access taken before core access");

  a_zero_fill: assert property (
    s_q.mem.we && s_q.fmt[1] |-> s_q.mem.wdata[23:16] == 8'h0 &&
    (s_q.fmt[0] ? s_q.mem.wdata[15:8] == 8'h0 : s_q.mem.wdata[7:0] == 8'h0))
    else $error("unused byte not zero");

  a_page_carry: assert property (
    s_q.dst == bdmm_pkg::D_BYTES && s_q.byte_done && s_q.eaddr == 14'h3fff
    && !s_q.ahb_wr |=> s_q.eaddr == 14'h0 && s_q.page == $past(s_q.page) + 8'h1)
    else $error("page did not advance on address wrap");

  a_restart_hold: assert property (
    s_q.irq && $past(s_q.ctx) |-> s_q.restart ##1 !s_q.hold)
    else $error("restart or release missing at end of held transfer");

endmodule : bdmm_top

`default_nettype wire

// [testbench/bdmm_byte_mem.sv]
/* Byte-wide external memory model on the block's pins.
   Assumes the page stands on data 23:16 while a byte read is on. */
`timescale 1ns/1ps
`default_nettype none
module bdmm_byte_mem (
  input wire logic sys_clk,
  input wire bdmm_pkg::bdmm_ext_s ext_out,
  output logic [23:0] ext_data_in,
  output logic [7:0] wr_byte
);
  logic [23:0] last_q = 24'h0;
  logic rd;
  logic [7:0] b;
  assign rd = !ext_out.bms_n && !ext_out.rd_n;
  // Content is a fixed function of page and byte address
  assign b = ext_out.addr[7:0] ^ ext_out.data[23:16] ^ 8'h5a;
  // A released bus shows the inverse of the last value, never a held copy
  assign ext_data_in = rd ? {ext_out.data[23:16], b, 8'h00} : ~last_q;
  always_ff @(posedge sys_clk) last_q <= ext_data_in;
  // Last byte written, taken from data 15:8
  always_ff @(posedge sys_clk) begin
    if (!ext_out.bms_n && !ext_out.wr_n) wr_byte <= ext_out.data[15:8];
  end
endmodule : bdmm_byte_mem
`default_nettype wire

// [testbench/tb.sv]
/* Self-checking bench of the byte DMA and memory map block.
   Assumes a zero-wait AHB-Lite slave and the byte memory model. */
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic sys_clk, reset, hsel, hwrite, hreadyout, hresp, map_pin, br_n;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic core_ack, core_ext, core_hold, core_restart, dma_irq;
  logic [23:0] core_rdata, mem_rdata, ext_in;
  logic [7:0] wr_byte;
  bdmm_pkg::bdmm_core_req_s creq;
  bdmm_pkg::bdmm_mem_s mem_out;
  bdmm_pkg::bdmm_ext_s ext_out;
  bdmm_pkg::bdmm_mem_s wq[$];
  int err_total, n_tests, irqs, rsts;
  bdmm_top i_dut (.sys_clk(sys_clk), .reset(reset), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .core_req(creq), .core_ack(core_ack),
    .core_ext(core_ext), .core_rdata(core_rdata), .core_hold(core_hold),
    .core_restart(core_restart), .dma_irq(dma_irq), .mem_out(mem_out),
    .mem_rdata(mem_rdata), .map_select_pin(map_pin), .bus_req_n(br_n),
    .ext_data_in(ext_in), .ext_out(ext_out));
  bdmm_byte_mem i_mem (.sys_clk(sys_clk), .ext_out(ext_out),
    .ext_data_in(ext_in), .wr_byte(wr_byte));
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (mem_out.req && mem_out.we) wq.push_back(mem_out);
    if (dma_irq) irqs++;
    if (core_restart) rsts++;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask : chk
  task end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim
  task tick(inout int k);
    k++;
    if (k > 3000) begin
      err_total++;
      end_sim();
    end
    @(posedge sys_clk);
  endtask : tick
  task rdy;
    int k;
    k = 0;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) tick(k);
  endtask : rdy
  task ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    rdy();
    rd = hrdata;
    chk(hresp, 32'h0, "response");
  endtask : ahb
  task rdchk(input logic [31:0] a, input logic [31:0] e, input string m);
    ahb(1'b0, a, 32'h0);
    chk(rd, e, m);
  endtask : rdchk
  task t_regs;
    rdchk(32'h20, 32'hb, "composite enables");
    rdchk(32'h18, 32'h77, "wait counts");
    ahb(1'b1, 32'h1c, 32'habc);
    rdchk(32'h1c, 32'habc, "io waits");
    ahb(1'b1, 32'h44, 32'h1234);
    rdchk(32'h44, 32'h0, "unmapped");
    rdchk(32'h4, 32'h0, "unmapped write ignored");
    $display("test regs done");
  endtask : t_regs
  task t_dma(input logic [1:0] f, input int n, input logic [7:0] pg,
             input logic [13:0] ea, input logic cx);
    logic [21:0] e;
    logic [23:0] w;
    logic hs;
    int k, j, i, r;
    wq.delete();
    i = irqs;
    r = rsts;
    hs = 1'b0;
    ahb(1'b1, 32'h0, {28'h0, cx, 1'b0, f});
    ahb(1'b1, 32'h4, 32'h100);
    ahb(1'b1, 32'h8, {18'h0, ea});
    ahb(1'b1, 32'hc, {24'h0, pg});
    ahb(1'b1, 32'h10, n);
    k = 0;
    // Page and address registers are left alone while busy
    while (irqs == i) begin
      hs = hs | core_hold;
      tick(k);
    end
    @(posedge sys_clk);
    chk(hs, cx, "core hold");
    chk(rsts - r, cx, "restart");
    chk(wq.size(), n, "word count");
    e = {pg, ea};
    for (k = 0; k < n; k++) begin
      w = 24'h0;
      for (j = 0; j < ((f == 2'h0) ? 3 : (f == 2'h1) ? 2 : 1); j++) begin
        w = {w[15:0], e[7:0] ^ e[21:14] ^ 8'h5a};
        e = e + 22'h1;
      end
      if (f == 2'h2) w = {8'h0, w[7:0], 8'h0};
      chk(wq[k].wdata, w, "word data");
      chk(wq[k].addr, 14'h100 + k, "internal address");
      chk(wq[k].is_pm, f == 2'h0, "memory kind");
    end
    rdchk(32'h10, 32'h0, "count at end");
    $display("test dma format %0d done", f);
  endtask : t_dma
  task t_ovl(input logic [1:0] ov);
    int k;
    logic seen;
    ahb(1'b1, 32'h14, {30'h0, ov});
    creq.req <= 1'b1;
    creq.space <= bdmm_pkg::SP_PM;
    creq.addr <= 14'h2345;
    seen = 1'b0;
    k = 0;
    do begin
      tick(k);
      if (ext_out.pms_n === 1'b0) begin
        seen = 1'b1;
        chk(ext_out.addr, {ov[1], 13'h0345}, "overlay address");
        chk(ext_out.cms_n, 32'h0, "composite select");
      end
    end while (core_ack !== 1'b1);
    creq.req <= 1'b0;
    chk(seen, ov != 2'h0, "external strobe");
    chk(core_ext, ov != 2'h0, "external flag");
    $display("test overlay %0d done", ov);
  endtask : t_ovl
  task t_out;
    int k, i;
    i = irqs;
    mem_rdata <= 24'h12c3a5;
    ahb(1'b1, 32'h0, 32'h7);
    ahb(1'b1, 32'h8, 32'h20);
    ahb(1'b1, 32'h10, 32'h1);
    k = 0;
    while (irqs == i) tick(k);
    chk(wr_byte, 32'ha5, "byte out");
    rdchk(32'h10, 32'h0, "count after out");
    $display("test dma out done");
  endtask : t_out
  task t_map;
    int k;
    ahb(1'b1, 32'h14, 32'h0);
    map_pin <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rdchk(32'h24, 32'h4, "map status");
    creq.req <= 1'b1;
    creq.space <= bdmm_pkg::SP_PM;
    creq.addr <= 14'h0345;
    k = 0;
    do tick(k); while (core_ack !== 1'b1);
    creq.req <= 1'b0;
    chk(core_ext, 32'h1, "map external");
    chk(ext_out.addr, 32'h0345, "map address");
    map_pin <= 1'b0;
    $display("test map done");
  endtask : t_map
  initial begin
    {hsel, hwrite, htrans, haddr, hwdata, map_pin} = '0;
    hsize = 3'h2;
    creq = '0;
    mem_rdata = 24'h0;
    br_n = 1'b1;
    reset = 1'b1;
    err_total = 0;
    n_tests = 0;
    irqs = 0;
    rsts = 0;
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    t_regs();
    t_dma(2'h0, 1, 8'h05, 14'h3fff, 1'b0);
    t_dma(2'h1, 2, 8'h00, 14'h0010, 1'b1);
    t_dma(2'h2, 1, 8'h7f, 14'h0200, 1'b0);
    t_dma(2'h3, 1, 8'h01, 14'h3ffe, 1'b0);
    for (int v = 0; v < 3; v++) t_ovl(v[1:0]);
    t_out();
    t_map();
    end_sim();
  end
endmodule : tb
`default_nettype wire
